// ==== rtl/pwm_pkg.sv ====
package pwm_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] ADDR_TMAP = 12'hFAE; // Timer map register
  localparam logic [1:0][11:0] ADDR_DCL = {12'hF9F, 12'hFA2}; // Duty low, per channel
  localparam logic [1:0][11:0] ADDR_DCH = {12'hFA0, 12'hFA3}; // Duty high, per channel
  localparam logic [1:0][11:0] ADDR_CON = {12'hFA1, 12'hFA4}; // Control, per channel
  localparam logic [7:0] TMR_PAGE = 8'hF8; // Timer block, 4 bytes per timer
  localparam logic [1:0] TMR_CNT = 2'h0; // Timer count (read only)
  localparam logic [1:0] TMR_PER = 2'h1; // Timer period
  localparam logic [1:0] TMR_CTL = 2'h2; // Timer control

  // ****************************************
  // Field positions
  // ****************************************
  localparam int EN_BIT = 7; // Channel enable
  localparam int OUT_BIT = 5; // Channel output level (read only)
  localparam int POL_BIT = 4; // Output invert
  localparam int TON_BIT = 7; // Timer run
  localparam int DCL_LSB = 6; // Duty low bits sit in 7:6
  localparam int SEL_LSB = 2; // First channel select in timer map

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [5:0] TMAP_RST = 6'h15; // Timer map reset
  localparam logic [7:0] PER_RST = 8'hFF; // Timer period reset
  localparam logic [7:0] BYTE_RST = 8'h00; // All other registers

  // ****************************************
  // Timing counts
  // ****************************************
  localparam logic [1:0] SUB_LAST = 2'h3; // Four sub-counts per timer step
  localparam logic [3:0][5:0] PRE_LAST = {6'h3F, 6'h0F, 6'h03, 6'h00}; // 1,4,16,64

  typedef enum logic [1:0] {
    PS_1 = 2'b00,
    PS_4 = 2'b01,
    PS_16 = 2'b10,
    PS_64 = 2'b11
  } prescale_t;
endpackage

// ==== rtl/eight_bit_timer.sv ====
`timescale 1ns/1ps
module eight_bit_timer (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic run, // Timer on and not asleep
  input wire logic [1:0] prescale, // Prescale select
  input wire logic [7:0] period, // Period register
  output logic [7:0] count, // Timer count
  output logic tick, // Time base advances this cycle
  output logic roll, // Period rollover this cycle
  output logic [9:0] tb_next // Time base after this cycle
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [5:0] pre; // Prescale divider
    logic [1:0] sub; // Sub-count, two low time base bits
    logic [7:0] cnt; // Eight-bit count
  } tstate_t;

  tstate_t s_reg; // Registered state
  tstate_t s_next; // Next state

  // ****************************************
  // Counting
  // ****************************************
  // No postscaler exists here, so nothing can skew the period (see R14)
  always_comb begin
    s_next = s_reg;
    tick = run && (s_reg.pre == pwm_pkg::PRE_LAST[prescale]); // see R16
    // Four sub-steps per count, so a period spans (period+1)*4 steps (see R11)
    roll = tick && (s_reg.sub == pwm_pkg::SUB_LAST) && (s_reg.cnt == period);
    if (run) begin
      s_next.pre = tick ? 6'h00 : s_reg.pre + 6'h01;
    end
    if (roll) begin
      // Count cleared on the step after a period match (see R13)
      s_next.sub = 2'h0;
      s_next.cnt = 8'h00;
    end else if (tick) begin
      // Sub-count of prescaled clocks under the count gives 10 bits (see R2)
      s_next.sub = s_reg.sub + 2'h1;
      if (s_reg.sub == pwm_pkg::SUB_LAST) begin
        s_next.cnt = s_reg.cnt + 8'h01;
      end
    end
    tb_next = {s_next.cnt, s_next.sub};
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.cnt;

  // Asleep or off, nothing moves
  hold_count_a: assert property (@(posedge clk) disable iff (rst) // see R17
    !run |=> $stable(s_reg)) else $error("timer moved while stopped");
  // Rollover returns the count to zero
  roll_clear_a: assert property (@(posedge clk) disable iff (rst) // see R13
    roll |=> (count == 8'h00) && (s_reg.sub == 2'h0)) else $error("count not cleared");
endmodule

// ==== rtl/pwm_channel.sv ====
`timescale 1ns/1ps
module pwm_channel (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic en, // Channel enable
  input wire logic output_invert, // Output invert
  input wire logic [9:0] duty, // Written duty value
  input wire logic [7:0] period, // Selected period register
  input wire logic tick, // Selected time base advances
  input wire logic roll, // Selected timer rollover
  input wire logic [9:0] tb_next, // Selected time base, next value
  output logic pin // Modulated output
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [9:0] dbuf; // Buffered duty
    logic act; // Output active before inversion
    logic pin; // Output after inversion
  } cstate_t;

  cstate_t s_reg; // Registered state
  cstate_t s_next; // Next state
  logic [10:0] lim; // Four times (period plus one)
  logic full; // Duty at or beyond the period

  // ****************************************
  // Waveform
  // ****************************************
  always_comb begin
    s_next = s_reg;
    lim = {({1'b0, period} + 9'h001), 2'b00};
    full = ({1'b0, s_reg.dbuf} >= lim); // see R7
    if (roll) begin
      s_next.dbuf = duty; // see R8
    end
    if (!en) begin
      s_next.act = 1'b0; // see R19
    end else if (roll) begin
      // Set at rollover unless the new duty is zero (see R4, R13)
      s_next.act = (duty != 10'h000);
    end else if (tick && (tb_next == s_reg.dbuf) && !full) begin
      s_next.act = 1'b0; // see R5
    end
    s_next.pin = s_next.act ^ output_invert; // see R10
  end

  // Register the state
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pin = s_reg.pin;

  // Buffer only reloads at rollover
  duty_buffer_a: assert property (@(posedge clk) disable iff (rst) // see R8
    !roll |=> $stable(s_reg.dbuf)) else $error("duty buffer changed mid period");
  // Rollover turns the output on for non-zero duty
  roll_set_a: assert property (@(posedge clk) disable iff (rst) // see R4
    en && roll && (duty != 10'h000) |=> s_reg.act) else $error("not set at rollover");
  // Zero duty stays off
  zero_duty_a: assert property (@(posedge clk) disable iff (rst) // see R13
    en && roll && (duty == 10'h000) |=> !s_reg.act) else $error("zero duty went active");
  // Match clears the output
  match_clear_a: assert property (@(posedge clk) disable iff (rst) // see R5
    en && !roll && tick && (tb_next == s_reg.dbuf) && !full |=> !s_reg.act)
    else $error("match did not clear");
  // Full duty never clears
  full_duty_a: assert property (@(posedge clk) disable iff (rst) // see R7
    en && s_reg.act && full && !roll |=> s_reg.act) else $error("full duty cleared");
  // Disabled output inactive and inversion applied
  level_inv_a: assert property (@(posedge clk) disable iff (rst) // see R19
    ##1 (pin == (s_reg.act ^ $past(output_invert))) && ($past(!en) -> !s_reg.act))
    else $error("wrong output level");
endmodule

// ==== rtl/pwm_top.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
//
// Contract
// R1 - Two-bit field picks one of four timers
// R2 - Ten-bit duty resolution from count plus sub-count
// R3 - Shared period per timer, separate duty
// R4 - Output goes active at timer rollover
// R5 - Output goes inactive on duty match
// R6 - Duty from high byte and low 7:6
// R7 - Duty at or beyond period: never cleared
// R8 - Duty double buffered, reloaded at rollover
// R9 - Software writes both duty bytes before rollover
// R10 - Invert bit flips the output
// R11 - Period is (period+1)*4*clock*prescale
// R12 - Timer must run at clock over four
// R13 - Rollover clears count, sets output, loads buffers
// R14 - Postscaler has no effect
// R15 - Duty registers writable at any time
// R16 - Low time base bits count prescaled clocks
// R17 - Sleep freezes timer and outputs
// R18 - Reset restores all registers
// R19 - Enable cleared holds output inactive
// R20 - Status bit shows present output level
//
module pwm_top (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic sleep, // Freeze request
  input wire logic [11:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  output logic [1:0] pwm_out // Modulated outputs
);
  // ****************************************
  // Register state
  // ****************************************
  typedef struct packed {
    logic [3:0][7:0] per; // Timer periods
    logic [3:0] ton; // Timer run bits
    logic [3:0][1:0] tps; // Timer prescale selects
    logic [1:0][7:0] dh; // Duty high bytes
    logic [1:0][1:0] dl; // Duty low bits
    logic [1:0] en; // Channel enables
    logic [1:0] output_invert; // Channel inversion
    logic [5:0] tmap; // Timer map, incl. unused capture field
    logic [7:0] rdata; // Read data
  } regs_t;

  regs_t r_reg; // Registered state
  regs_t r_next; // Next state

  logic [3:0][7:0] t_count; // Timer counts
  logic [3:0] t_tick; // Timer time base steps
  logic [3:0] t_roll; // Timer rollovers
  logic [3:0][9:0] t_tbn; // Timer time base next values
  logic [1:0] pin; // Channel outputs
  logic [7:0] rd_val; // Value for the addressed register

  // Timer picked by a channel from the timer map
  function automatic logic [1:0] chan_sel(input logic [5:0] map, input int c);
    chan_sel = map[pwm_pkg::SEL_LSB + 2 * c +: 2]; // see R1
  endfunction

  // Timer register hit: returns one when address is in the timer page at offset f
  function automatic logic tmr_hit(input logic [11:0] a, input logic [1:0] f);
    tmr_hit = (a[11:4] == pwm_pkg::TMR_PAGE) && (a[1:0] == f);
  endfunction

  // ****************************************
  // Timers
  // ****************************************
  // Each timer stops while asleep (see R17); one period feeds all its users (see R3)
  for (genvar t = 0; t < 4; t++) begin : g_tmr
    eight_bit_timer u_tmr (
      .clk(clk),
      .rst(rst),
      .run(r_reg.ton[t] && !sleep),
      .prescale(r_reg.tps[t]),
      .period(r_reg.per[t]),
      .count(t_count[t]),
      .tick(t_tick[t]),
      .roll(t_roll[t]),
      .tb_next(t_tbn[t])
    );
  end

  // ****************************************
  // Channels
  // ****************************************
  // Each channel follows its own timer choice (see R1)
  for (genvar c = 0; c < 2; c++) begin : g_chan
    pwm_channel u_chan (
      .clk(clk),
      .rst(rst),
      .en(r_reg.en[c]),
      .output_invert(r_reg.output_invert[c]),
      .duty({r_reg.dh[c], r_reg.dl[c]}),
      .period(r_reg.per[chan_sel(r_reg.tmap, c)]),
      .tick(t_tick[chan_sel(r_reg.tmap, c)]),
      .roll(t_roll[chan_sel(r_reg.tmap, c)]),
      .tb_next(t_tbn[chan_sel(r_reg.tmap, c)]),
      .pin(pin[c])
    );
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Unmapped addresses and reserved bits read as zero
  always_comb begin
    rd_val = 8'h00;
    if (addr == pwm_pkg::ADDR_TMAP) begin
      rd_val = {2'b00, r_reg.tmap};
    end
    for (int c = 0; c < 2; c++) begin
      if (addr == pwm_pkg::ADDR_DCH[c]) begin
        rd_val = r_reg.dh[c];
      end
      if (addr == pwm_pkg::ADDR_DCL[c]) begin
        rd_val = {r_reg.dl[c], 6'h00};
      end
      if (addr == pwm_pkg::ADDR_CON[c]) begin
        rd_val = 8'h00;
        rd_val[pwm_pkg::EN_BIT] = r_reg.en[c];
        rd_val[pwm_pkg::OUT_BIT] = pin[c]; // see R20
        rd_val[pwm_pkg::POL_BIT] = r_reg.output_invert[c];
      end
    end
    if (tmr_hit(addr, pwm_pkg::TMR_CNT)) begin
      rd_val = t_count[addr[3:2]];
    end
    if (tmr_hit(addr, pwm_pkg::TMR_PER)) begin
      rd_val = r_reg.per[addr[3:2]];
    end
    if (tmr_hit(addr, pwm_pkg::TMR_CTL)) begin
      rd_val = {r_reg.ton[addr[3:2]], 5'h00, r_reg.tps[addr[3:2]]};
    end
  end

  // ****************************************
  // Register writes
  // ****************************************
  // Duty bytes take writes any time; the buffers isolate the waveform (see R15).
  // A half-written duty can still be loaded if rollover falls between the two
  // writes, so software should write both bytes early in a period (see R9).
  always_comb begin
    r_next = r_reg;
    r_next.rdata = rd ? rd_val : 8'h00;
    if (wr) begin
      if (addr == pwm_pkg::ADDR_TMAP) begin
        r_next.tmap = wdata[5:0];
      end
      for (int c = 0; c < 2; c++) begin
        if (addr == pwm_pkg::ADDR_DCH[c]) begin
          r_next.dh[c] = wdata; // see R6
        end
        if (addr == pwm_pkg::ADDR_DCL[c]) begin
          r_next.dl[c] = wdata[pwm_pkg::DCL_LSB +: 2]; // see R6
        end
        if (addr == pwm_pkg::ADDR_CON[c]) begin
          r_next.en[c] = wdata[pwm_pkg::EN_BIT];
          r_next.output_invert[c] = wdata[pwm_pkg::POL_BIT];
        end
      end
      if (tmr_hit(addr, pwm_pkg::TMR_PER)) begin
        r_next.per[addr[3:2]] = wdata;
      end
      if (tmr_hit(addr, pwm_pkg::TMR_CTL)) begin
        r_next.ton[addr[3:2]] = wdata[pwm_pkg::TON_BIT];
        r_next.tps[addr[3:2]] = wdata[1:0];
      end
    end
  end

  // Register everything; reset restores every field (see R18)
  always_ff @(posedge clk) begin
    if (rst) begin
      r_reg.per <= {4{pwm_pkg::PER_RST}};
      r_reg.ton <= 4'h0;
      r_reg.tps <= {4{pwm_pkg::PS_1}};
      r_reg.dh <= {2{pwm_pkg::BYTE_RST}};
      r_reg.dl <= 4'h0;
      r_reg.en <= 2'h0;
      r_reg.output_invert <= 2'h0;
      r_reg.tmap <= pwm_pkg::TMAP_RST;
      r_reg.rdata <= pwm_pkg::BYTE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign rdata = r_reg.rdata;
  assign pwm_out = pin;

  // ****************************************
  // Checks
  // ****************************************
  // Reset values are in place right after reset
  reset_values_a: assert property (@(posedge clk) // see R18
    $past(rst) |-> (r_reg.tmap == pwm_pkg::TMAP_RST) && (r_reg.en == 2'h0)
      && (r_reg.per == {4{pwm_pkg::PER_RST}})) else $error("bad reset value");

  // Status bit reads the present output level
  out_status_a: assert property (@(posedge clk) disable iff (rst) // see R20
    rd && (addr == pwm_pkg::ADDR_CON[0]) |=> rdata[pwm_pkg::OUT_BIT] == $past(pin[0]))
    else $error("status bit differs from output");

  // Duty write lands without waiting for the timer
  duty_write_a: assert property (@(posedge clk) disable iff (rst) // see R15
    wr && (addr == pwm_pkg::ADDR_DCH[1]) |=> r_reg.dh[1] == $past(wdata))
    else $error("duty write lost");

  // Channel zero follows the timer picked by its field
  timer_pick_a: assert property (@(posedge clk) disable iff (rst) // see R1
    (r_reg.tmap[3:2] == 2'b10) && t_roll[2] && r_reg.en[0]
      && ({r_reg.dh[0], r_reg.dl[0]} != 10'h000)
      |=> pwm_out[0] == !r_reg.output_invert[0]) else $error("wrong timer used");

  // Reads answer in the next cycle only
  read_timing_a: assert property (@(posedge clk) disable iff (rst)
    !rd |=> rdata == 8'h00) else $error("read data outside its cycle");

  // Asleep, outputs hold their level
  sleep_hold_a: assert property (@(posedge clk) disable iff (rst) // see R17
    sleep && $past(sleep) && !wr && !$past(wr) |=> $stable(pwm_out))
    else $error("output moved in sleep");
endmodule

// ==== dv/test_pwm_top.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); end end

module test_pwm_top;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0; // System clock, 5 ns period
  logic rst = 1'b1; // Synchronous reset
  logic sleep = 1'b0; // Freeze request
  logic [11:0] addr = 12'h000; // Register address
  logic [7:0] wdata = 8'h00; // Write data
  logic wr = 1'b0; // Write strobe
  logic rd = 1'b0; // Read strobe
  logic [7:0] rdata; // Read data
  logic [1:0] pwm_out; // Modulated outputs
  int fail_count = 0; // Mismatches seen
  int samples_checked = 0; // Comparisons made
  int h0; // High cycles, channel 0
  int h1; // High cycles, channel 1
  int dm; // Duty clipped to full period
  int same; // Cycles with a frozen level
  logic [1:0] lv; // Level at sleep entry
  int exp1[4] = '{96, 48, 32, 24}; // Channel 1 highs per timer choice

  always #2.5 clk = ~clk;

  pwm_top uut (
    .clk(clk),
    .rst(rst),
    .sleep(sleep),
    .addr(addr),
    .wdata(wdata),
    .wr(wr),
    .rd(rd),
    .rdata(rdata),
    .pwm_out(pwm_out)
  );

  // ****************************************
  // Bus tasks
  // ****************************************
  // One-cycle write strobe; the caller's next edge is always a fresh one
  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  // Timer t register o sits at 0xF80 + 4t + o
  function automatic logic [11:0] taddr(input int t, input logic [1:0] o);
    taddr = {pwm_pkg::TMR_PAGE, 2'(t), o};
  endfunction

  // Both duty bytes go in back to back, at no set point in the period
  task automatic set_duty(input int ch, input logic [9:0] d);
    wr_reg(pwm_pkg::ADDR_DCH[ch], d[9:2]);
    wr_reg(pwm_pkg::ADDR_DCL[ch], {d[1:0], 6'h00});
  endtask

  // Counting over whole periods keeps the result free of phase
  task automatic measure(input int n, output int c0, output int c1);
    c0 = 0;
    c1 = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (pwm_out[0] === 1'b1) c0++;
      if (pwm_out[1] === 1'b1) c1++;
    end
  endtask

  task automatic summarize();
    $display("checked %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ****************************************
  // Watchdog
  // ****************************************
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    // Reset state, unmapped read and read-only status bit
    `CHK(pwm_out, 2'b00)
    rd_chk(pwm_pkg::ADDR_TMAP, 8'h15);
    rd_chk(taddr(1, pwm_pkg::TMR_PER), 8'hFF);
    rd_chk(pwm_pkg::ADDR_CON[0], 8'h00);
    rd_chk(pwm_pkg::ADDR_DCH[1], 8'h00);
    rd_chk(12'hF90, 8'h00);
    wr_reg(pwm_pkg::ADDR_CON[1], 8'h20);
    rd_chk(pwm_pkg::ADDR_CON[1], 8'h00);
    $display("test reset done");

    // Timer t gets period t; the last one also prescales by 4
    // Timers 0 to 2 count at clock over four, the required rate; timer 3 counts four times slower
    for (int t = 0; t < 4; t++) begin
      wr_reg(taddr(t, pwm_pkg::TMR_PER), 8'(t));
      wr_reg(taddr(t, pwm_pkg::TMR_CTL), (t == 3) ? 8'h81 : 8'h80);
    end
    // Top bits of the map are unused and must read zero
    wr_reg(pwm_pkg::ADDR_TMAP, 8'hF1);
    rd_chk(pwm_pkg::ADDR_TMAP, 8'h31);
    wr_reg(pwm_pkg::ADDR_CON[0], 8'h80);
    // Four-clock period: duty d gives d high clocks, four or more is full
    for (int p = 0; p < 2; p++) begin
      wr_reg(pwm_pkg::ADDR_CON[0], p ? 8'h90 : 8'h80);
      for (int d = 0; d < 6; d++) begin
        set_duty(0, 10'(d));
        repeat (12) @(posedge clk);
        measure(40, h0, h1);
        dm = (d > 4) ? 4 : d;
        `CHK(h0, p ? 40 - 10 * dm : 10 * dm)
      end
    end
    set_duty(0, 10'h004);
    wr_reg(pwm_pkg::ADDR_CON[0], 8'h80);
    repeat (12) @(posedge clk);
    rd_chk(pwm_pkg::ADDR_CON[0], 8'hA0);
    // Disabled channel rests at its inactive level, inverted here
    wr_reg(pwm_pkg::ADDR_CON[0], 8'h10);
    measure(8, h0, h1);
    `CHK(h0, 8)
    rd_chk(pwm_pkg::ADDR_CON[0], 8'h30);
    wr_reg(pwm_pkg::ADDR_CON[0], 8'h00);
    measure(8, h0, h1);
    `CHK(h0, 0)
    $display("test duty and invert done");

    // Channel 1 walks all four timer choices while channel 0 stays on timer 0
    set_duty(0, 10'h001);
    wr_reg(pwm_pkg::ADDR_CON[0], 8'h80);
    set_duty(1, 10'h002);
    wr_reg(pwm_pkg::ADDR_CON[1], 8'h80);
    for (int s = 0; s < 4; s++) begin
      wr_reg(pwm_pkg::ADDR_TMAP, {2'b00, 2'(s), 2'b00, 2'b01});
      repeat (140) @(posedge clk);
      measure(192, h0, h1);
      `CHK(h1, exp1[s])
      `CHK(h0, 48)
    end
    // Channel 0 moves to timer 2: one high clock in every twelve
    wr_reg(pwm_pkg::ADDR_TMAP, 8'h39);
    repeat (140) @(posedge clk);
    measure(192, h0, h1);
    `CHK(h0, 16)
    wr_reg(pwm_pkg::ADDR_TMAP, 8'h31);
    $display("test timer select done");

    // New duty written mid-period must wait for the next rollover
    wr_reg(taddr(0, pwm_pkg::TMR_PER), 8'h03);
    set_duty(0, 10'h008);
    repeat (40) @(posedge clk);
    h0 = 0;
    for (int i = 0; i < 200 && h0 == 0; i++) begin
      @(posedge clk);
      #1;
      if (pwm_out[0] === 1'b1) h0 = 1;
    end
    if (h0 == 0) begin
      fail_count++;
      summarize();
    end
    wr_reg(pwm_pkg::ADDR_DCH[0], 8'h00);
    measure(14, h0, h1);
    `CHK(h0, 5)
    measure(32, h0, h1);
    `CHK(h0, 0)
    $display("test double buffer done");

    // Sleep freezes both outputs; counting resumes afterwards
    @(posedge clk);
    sleep <= 1'b1;
    @(posedge clk);
    #1;
    lv = pwm_out;
    same = 0;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (pwm_out === lv) same++;
    end
    `CHK(same, 100)
    @(posedge clk);
    sleep <= 1'b0;
    repeat (140) @(posedge clk);
    measure(192, h0, h1);
    `CHK(h1, 24)
    $display("test sleep done");
    summarize();
  end
endmodule
